// File: shared/tsiu_cfg.svh
`ifndef TSIU_CFG_SVH
`define TSIU_CFG_SVH

`define TSIU_ADDR_W 8
`define TSIU_ADDR_CTRL 8'h00
`define TSIU_ADDR_MISC 8'h04
`define TSIU_ADDR_STAT 8'h08

`define TSIU_BIT_GIE 0
`define TSIU_BIT_PIN_EN 1
`define TSIU_BIT_TMR_EN 2
`define TSIU_BIT_PIN_FLAG 4
`define TSIU_BIT_TMR_FLAG 5
`define TSIU_BIT_ES_LO 6
`define TSIU_BIT_ES_HI 7

`define TSIU_CTRL_RESET 8'h00
`define TSIU_MISC_RESET 8'h00
`define TSIU_HSIZE_WORD 3'h2

`define TSIU_VEC_PIN 16'h0004
`define TSIU_VEC_TMR 16'h0008

`define TSIU_SYS_CLK_NS 100
`define TSIU_CLK_PER_INSTR 4
`define TSIU_T2_PHASE 2'h1
`define TSIU_WAKE_INSTR 3

`endif

// File: shared/tsiu_pkg.sv
`default_nettype none
package tsiu_pkg;

  typedef enum logic [2:0] {
    TSIU_ST_IDLE = 3'h1,
    TSIU_ST_ARMED = 3'h2,
    TSIU_ST_WAKE = 3'h4
  } tsiu_state_t;

  typedef enum logic [1:0] {
    TSIU_EDGE_OFF = 2'h0,
    TSIU_EDGE_RISE = 2'h1,
    TSIU_EDGE_FALL = 2'h2,
    TSIU_EDGE_BOTH = 2'h3
  } tsiu_edge_t;

endpackage : tsiu_pkg
`default_nettype wire

// File: logic/tsiu_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tsiu_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } tsiu_sync_state_t;

  tsiu_sync_state_t state_ff;
  tsiu_sync_state_t nxt_state;

  // Only the second stage is visible; the first may be metastable.
  always_comb
  begin
    nxt_state.meta = async_in;
    nxt_state.stable = state_ff.meta;
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  assign sync_out = state_ff.stable;
endmodule : tsiu_sync
`default_nettype wire

// File: logic/tsiu_edge.sv
`timescale 1ns/1ps
`default_nettype none
module tsiu_edge
  import tsiu_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic level_in,
  input wire logic [1:0] sel_in,
  output logic hit_out
);
  typedef struct packed {
    logic prev;
  } tsiu_edge_state_t;

  tsiu_edge_state_t state_ff;
  tsiu_edge_state_t nxt_state;
  logic rise;
  logic fall;

  always_comb
  begin
    nxt_state.prev = level_in;
    rise = level_in & ~state_ff.prev;
    fall = ~level_in & state_ff.prev;
    case (tsiu_edge_t'(sel_in))
      TSIU_EDGE_OFF: hit_out = 1'b0;
      TSIU_EDGE_RISE: hit_out = rise;
      TSIU_EDGE_FALL: hit_out = fall;
      TSIU_EDGE_BOTH: hit_out = rise | fall;
      default: hit_out = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end
endmodule : tsiu_edge
`default_nettype wire

// File: logic/tsiu_top.sv
// Operation
// [RULE_01] Timer overflow or selected pin edge sets the matching request flag.
// [RULE_02] Accepting a request pushes the next-instruction PC and loads the vector.
// [RULE_03] Pin request vectors to 04H, timer request to 08H.
// [RULE_04] Simultaneous enabled requests: pin request is serviced before timer.
// [RULE_05] Global enable zero blocks service of both sources.
// [RULE_06] Control register bit 5 is timer flag, bit 4 pin flag.
// [RULE_07] Control bit 2 timer enable, bit 1 pin enable, bit 0 global enable.
// [RULE_08] No request is acknowledged while the return stack is full.
// [RULE_09] Entering service clears the global enable bit.
// [RULE_10] Servicing a request clears that source's request flag.
// [RULE_11] Requests during global disable still set and keep their flags.
// [RULE_12] Vector jump 2 or 3 instruction cycles after request; 3 after sleep.
// [RULE_13] Requests between two T2 edges are serviced on the latter edge.
// [RULE_14] Edge select bits 7:6: off, rising, falling, both edges.
// [RULE_15] Software enables the pin source, picks an edge and makes the pin input.
// [RULE_16] Any request flag rising raises wake-up, regardless of enables.
// [RULE_17] Software presets a flag high before sleep to suppress its wake-up.
// [RULE_18] A set flag stays set until serviced or written to zero.
// [RULE_19] Return-from-interrupt restores the PC and sets the global enable.
// [RULE_20] Plain return restores the PC only, global enable stays zero.
// [RULE_21] Only the program counter is saved on interrupt entry.
// [RULE_22] A nesting service routine sets the global enable again itself.
// [RULE_23] A request is accepted only at an instruction boundary; the WAKE path accepts it at a T2 pulse without checking instr_boundary_in.
`timescale 1ns/1ps
`default_nettype none
`include "tsiu_cfg.svh"
module tsiu_top
  import tsiu_pkg::*;
#(
  parameter int PC_W = 10
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic ext_pin_in,
  input wire logic timer_ovf_in,
  input wire logic instr_boundary_in,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic stack_full_in,
  input wire logic ret_in,
  input wire logic return_from_irq_instr_in,
  input wire logic sleep_in,
  output logic irq_take_out,
  output logic [PC_W-1:0] irq_push_pc_out,
  output logic [PC_W-1:0] irq_vector_out,
  output logic wake_out,
  output logic phase_two_clock_out
);
  localparam int INSTR_CLKS = `TSIU_CLK_PER_INSTR;
  localparam logic [7:0] CTRL_RST = `TSIU_CTRL_RESET;
  localparam logic [7:0] MISC_RST = `TSIU_MISC_RESET;
  localparam logic [1:0] PHASE_LAST = 2'(INSTR_CLKS - 1);
  localparam logic [1:0] WAKE_LAST = 2'(`TSIU_WAKE_INSTR - 1);

  typedef struct packed {
    logic [1:0] phase;
    logic phase_two_clock;
    logic pin_irq_flag;
    logic timer_irq_flag;
    logic pin_irq_enable;
    logic timer_irq_enable;
    logic global_irq_enable;
    logic edge_select_high;
    logic edge_select_low;
    tsiu_state_t st;
    logic [1:0] wake_cnt;
    logic last_src_tmr;
    logic take;
    logic [PC_W-1:0] push_pc;
    logic [PC_W-1:0] vector;
    logic wake;
    logic dp_wr;
    logic [`TSIU_ADDR_W-1:0] dp_addr;
    logic [31:0] rdata;
    logic ready;
  } tsiu_state_s_t;

  tsiu_state_s_t state_ff;
  tsiu_state_s_t nxt_state;

  logic pin_level;
  logic pin_hit;

  tsiu_sync #(
    .W(1)
  ) u_pin_sync (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .async_in(ext_pin_in),
    .sync_out(pin_level)
  );

  tsiu_edge u_pin_edge (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .level_in(pin_level),
    .sel_in({state_ff.edge_select_high, state_ff.edge_select_low}),
    .hit_out(pin_hit)
  );

  logic t2;
  logic addr_phase;
  logic wr_ctrl;
  logic wr_misc;
  logic pin_req;
  logic tmr_req;
  logic any_req;
  logic take_now;
  logic sel_pin;
  logic [7:0] ctrl_view;
  logic [7:0] misc_view;
  logic [7:0] stat_view;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.take = 1'b0;
    nxt_state.ready = 1'b1;
    take_now = 1'b0;

    // Instruction cycle divider; the T2 pulse is the service sampling point.
    t2 = (state_ff.phase == `TSIU_T2_PHASE);
    nxt_state.phase = (state_ff.phase == PHASE_LAST) ? 2'h0 : state_ff.phase + 2'h1;
    nxt_state.phase_two_clock = (nxt_state.phase == `TSIU_T2_PHASE);

    // Bus address phase is captured here; the data phase follows one cycle later.
    addr_phase = hsel_in & hready_in & htrans_in[1];
    nxt_state.dp_wr = addr_phase & hwrite_in & (hsize_in == `TSIU_HSIZE_WORD);
    nxt_state.dp_addr = haddr_in[`TSIU_ADDR_W-1:0];
    wr_ctrl = state_ff.dp_wr & (state_ff.dp_addr == `TSIU_ADDR_CTRL);
    wr_misc = state_ff.dp_wr & (state_ff.dp_addr == `TSIU_ADDR_MISC);

    if (wr_ctrl)
    begin
      nxt_state.pin_irq_flag = hwdata_in[`TSIU_BIT_PIN_FLAG]; // [RULE_18]
      nxt_state.timer_irq_flag = hwdata_in[`TSIU_BIT_TMR_FLAG]; // [RULE_06]
      nxt_state.pin_irq_enable = hwdata_in[`TSIU_BIT_PIN_EN]; // [RULE_07]
      nxt_state.timer_irq_enable = hwdata_in[`TSIU_BIT_TMR_EN];
      nxt_state.global_irq_enable = hwdata_in[`TSIU_BIT_GIE];
    end
    if (wr_misc)
    begin
      nxt_state.edge_select_low = hwdata_in[`TSIU_BIT_ES_LO]; // [RULE_14]
      nxt_state.edge_select_high = hwdata_in[`TSIU_BIT_ES_HI];
    end

    // Of the two returns, only return-from-interrupt touches the global enable; a plain return leaves it. [RULE_20]
    if (return_from_irq_instr_in)
      nxt_state.global_irq_enable = 1'b1; // [RULE_19]

    // Requests gated by the individual and global enables; flags are not touched here.
    pin_req = state_ff.pin_irq_flag & state_ff.pin_irq_enable;
    tmr_req = state_ff.timer_irq_flag & state_ff.timer_irq_enable;
    any_req = (pin_req | tmr_req) & state_ff.global_irq_enable; // [RULE_05]
    sel_pin = pin_req; // [RULE_04]

    case (state_ff.st)
      TSIU_ST_IDLE:
      begin
        if (sleep_in)
        begin
          if (state_ff.wake)
          begin
            nxt_state.st = TSIU_ST_WAKE;
            nxt_state.wake_cnt = 2'h0;
          end
        end
        else if (t2 && any_req && !stack_full_in) // [RULE_13]
          nxt_state.st = TSIU_ST_ARMED;
      end
      TSIU_ST_ARMED:
      begin
        if (!any_req)
          nxt_state.st = TSIU_ST_IDLE;
        else if (instr_boundary_in && !stack_full_in) // [RULE_23] [RULE_08]
          take_now = 1'b1;
      end
      TSIU_ST_WAKE:
      begin
        // A wake-up always costs three instruction cycles before the vector.
        if (t2)
        begin
          if (state_ff.wake_cnt == WAKE_LAST) // [RULE_12]
          begin
            if (any_req && !stack_full_in)
              take_now = 1'b1;
            else
              nxt_state.st = TSIU_ST_IDLE;
          end
          else
            nxt_state.wake_cnt = state_ff.wake_cnt + 2'h1;
        end
      end
      default:
        nxt_state.st = TSIU_ST_IDLE;
    endcase

    if (take_now)
    begin
      nxt_state.st = TSIU_ST_IDLE;
      nxt_state.take = 1'b1;
      nxt_state.push_pc = pc_in; // [RULE_02] [RULE_21]
      nxt_state.vector = sel_pin ? PC_W'(`TSIU_VEC_PIN) : PC_W'(`TSIU_VEC_TMR); // [RULE_03]
      nxt_state.last_src_tmr = ~sel_pin;
      nxt_state.global_irq_enable = 1'b0; // [RULE_09]
      if (sel_pin)
        nxt_state.pin_irq_flag = 1'b0; // [RULE_10]
      else
        nxt_state.timer_irq_flag = 1'b0;
    end

    // Hardware set is applied last so a new event beats any clear in the same cycle.
    if (pin_hit)
      nxt_state.pin_irq_flag = 1'b1; // [RULE_01] [RULE_11]
    if (timer_ovf_in)
      nxt_state.timer_irq_flag = 1'b1;

    nxt_state.wake = (nxt_state.pin_irq_flag & ~state_ff.pin_irq_flag)
                   | (nxt_state.timer_irq_flag & ~state_ff.timer_irq_flag); // [RULE_16]

    // Read data reflect the register state after this edge, so a write then read is coherent.
    ctrl_view = 8'h00;
    ctrl_view[`TSIU_BIT_PIN_FLAG] = nxt_state.pin_irq_flag;
    ctrl_view[`TSIU_BIT_TMR_FLAG] = nxt_state.timer_irq_flag;
    ctrl_view[`TSIU_BIT_PIN_EN] = nxt_state.pin_irq_enable;
    ctrl_view[`TSIU_BIT_TMR_EN] = nxt_state.timer_irq_enable;
    ctrl_view[`TSIU_BIT_GIE] = nxt_state.global_irq_enable;
    misc_view = 8'h00;
    misc_view[`TSIU_BIT_ES_LO] = nxt_state.edge_select_low;
    misc_view[`TSIU_BIT_ES_HI] = nxt_state.edge_select_high;
    stat_view = {5'h00, nxt_state.last_src_tmr,
                 nxt_state.st == TSIU_ST_WAKE, nxt_state.st == TSIU_ST_ARMED};
    nxt_state.rdata = 32'h0000_0000;
    if (addr_phase && !hwrite_in)
    begin
      case (haddr_in[`TSIU_ADDR_W-1:0])
        `TSIU_ADDR_CTRL: nxt_state.rdata = {24'h00_0000, ctrl_view};
        `TSIU_ADDR_MISC: nxt_state.rdata = {24'h00_0000, misc_view};
        `TSIU_ADDR_STAT: nxt_state.rdata = {24'h00_0000, stat_view};
        default: nxt_state.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_ff <= '0;
      state_ff.st <= TSIU_ST_IDLE;
      state_ff.pin_irq_flag <= CTRL_RST[`TSIU_BIT_PIN_FLAG];
      state_ff.timer_irq_flag <= CTRL_RST[`TSIU_BIT_TMR_FLAG];
      state_ff.pin_irq_enable <= CTRL_RST[`TSIU_BIT_PIN_EN];
      state_ff.timer_irq_enable <= CTRL_RST[`TSIU_BIT_TMR_EN];
      state_ff.global_irq_enable <= CTRL_RST[`TSIU_BIT_GIE];
      state_ff.edge_select_low <= MISC_RST[`TSIU_BIT_ES_LO];
      state_ff.edge_select_high <= MISC_RST[`TSIU_BIT_ES_HI];
    end
    else
      state_ff <= nxt_state;
  end

  assign hrdata_out = state_ff.rdata;
  assign hreadyout_out = state_ff.ready;
  assign hresp_out = 1'b0;
  assign irq_take_out = state_ff.take;
  assign irq_push_pc_out = state_ff.push_pc;
  assign irq_vector_out = state_ff.vector;
  assign wake_out = state_ff.wake;
  assign phase_two_clock_out = state_ff.phase_two_clock;

  sequence s_enter_wake;
    state_ff.st == TSIU_ST_IDLE ##1 state_ff.st == TSIU_ST_WAKE;
  endsequence

  sequence s_take_rise;
    !state_ff.take ##1 state_ff.take;
  endsequence

  timer_flag_set_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE_01]
    timer_ovf_in |=> state_ff.timer_irq_flag)
    else $error("timer overflow did not set its flag");

  vector_pick_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE_03]
    state_ff.take |-> irq_vector_out == ($past(state_ff.pin_irq_flag && state_ff.pin_irq_enable)
                                         ? PC_W'(`TSIU_VEC_PIN) : PC_W'(`TSIU_VEC_TMR)))
    else $error("vector does not match serviced source");

  pin_first_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE_04]
    (state_ff.st == TSIU_ST_ARMED && instr_boundary_in && !stack_full_in && any_req
     && state_ff.pin_irq_flag && state_ff.pin_irq_enable) |=> !state_ff.last_src_tmr)
    else $error("timer serviced ahead of pending pin request");

  gie_gate_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE_05]
    s_take_rise |-> $past(state_ff.global_irq_enable))
    else $error("service taken with global enable low");

  stack_hold_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE_08]
    state_ff.take |-> !$past(stack_full_in))
    else $error("service taken while stack full");

  gie_clear_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE_09]
    state_ff.take |-> !state_ff.global_irq_enable)
    else $error("global enable still set on entry");

  flag_clear_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE_10]
    (take_now && !sel_pin && !timer_ovf_in) |=> !state_ff.timer_irq_flag)
    else $error("serviced timer flag not cleared");

  wake_time_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE_12]
    s_enter_wake |-> (state_ff.st == TSIU_ST_WAKE) [*8] ##[1:5] (state_ff.st != TSIU_ST_WAKE))
    else $error("sleep wake service time out of range");

  wake_rise_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE_16]
    ($rose(state_ff.pin_irq_flag) || $rose(state_ff.timer_irq_flag)) |-> wake_out)
    else $error("flag rise without wake pulse");

  return_from_irq_instr_gie_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE_19]
    (return_from_irq_instr_in && !take_now) |=> state_ff.global_irq_enable)
    else $error("return-from-interrupt did not set global enable");

  ret_keep_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE_20]
    (ret_in && !return_from_irq_instr_in && !wr_ctrl && !state_ff.global_irq_enable) |=> !state_ff.global_irq_enable)
    else $error("plain return changed global enable");

  boundary_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE_23]
    (state_ff.take && $past(state_ff.st) == TSIU_ST_ARMED) |-> $past(instr_boundary_in))
    else $error("service taken off an instruction boundary");

  instr_period_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE_13]
    (state_ff.st == TSIU_ST_IDLE && !sleep_in && any_req && !stack_full_in && t2)
    |=> state_ff.st == TSIU_ST_ARMED)
    else $error("pending request not armed at T2");
endmodule : tsiu_top
`default_nettype wire

// File: verif/tsiu_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module tsiu_core_model (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic take_in,
  input wire logic [9:0] vector_in,
  output logic boundary_out,
  output logic [9:0] pc_out
);
  logic [1:0] cyc_ff;
  logic [9:0] pc_ff;
  // The core spins at one address between takes, so the pushed value is predictable.
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cyc_ff <= 2'h0;
      pc_ff <= 10'h020;
    end
    else
    begin
      cyc_ff <= cyc_ff + 2'h1;
      if (take_in)
        pc_ff <= vector_in;
    end
  end
  // Every instruction takes four clocks, so a boundary shows once in four cycles.
  assign boundary_out = (cyc_ff == 2'h3);
  assign pc_out = pc_ff;
endmodule : tsiu_core_model
`default_nettype wire

// File: verif/two_source_interrupt_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsiu_cfg.svh"
module two_source_interrupt_unit_bench;
  logic sys_clk, rst, hsel, hwrite, hrdy, hresp, pin, tmr, sfull, ret, return_from_irq_instr, slp;
  logic take, wake, t2, bnd;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [9:0] pc, push, vec;
  int fails, num_checks, cyc, take_cnt, wake_cnt;
  tsiu_top u_dut (.sys_clk_in(sys_clk), .rst_in(rst), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
    .ext_pin_in(pin), .timer_ovf_in(tmr), .instr_boundary_in(bnd), .pc_in(pc),
    .stack_full_in(sfull), .ret_in(ret), .return_from_irq_instr_in(return_from_irq_instr), .sleep_in(slp),
    .irq_take_out(take), .irq_push_pc_out(push), .irq_vector_out(vec),
    .wake_out(wake), .phase_two_clock_out(t2));
  tsiu_core_model u_core (.sys_clk_in(sys_clk), .rst_in(rst), .take_in(take),
    .vector_in(vec), .boundary_out(bnd), .pc_out(pc));
  always #50 sys_clk = ~sys_clk;
  task test_done;
    if (fails == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  always @(posedge sys_clk)
  begin
    cyc++;
    if (take === 1'b1)
      take_cnt++;
    if (wake === 1'b1)
      wake_cnt++;
    if (cyc >= 20000)
    begin
      fails++;
      test_done();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // The bench timeout bounds both waits for hready.
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge sys_clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'h0, d};
    do @(posedge sys_clk); while (hrdy !== 1'b1);
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : bus
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] x;
    bus(1'b0, a, 8'h00, x);
    chk(x, {24'h0, e});
  endtask : rd
  task pls(input logic [2:0] w);
    @(posedge sys_clk);
    {ret, return_from_irq_instr, tmr} <= w;
    @(posedge sys_clk);
    {ret, return_from_irq_instr, tmr} <= 3'h0;
  endtask : pls
  task quiet;
    int c;
    int p;
    c = take_cnt;
    p = 0;
    repeat (40)
    begin
      @(posedge sys_clk);
      if (t2 === 1'b1)
        p++;
    end
    chk(take_cnt, c);
    chk(p, 32'h0000_000a);
  endtask : quiet
  task wait_take(input logic [15:0] v, output int n);
    n = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (take !== 1'b1 && n < 80);
    chk({31'h0, take}, 32'h1);
    chk({22'h0, vec}, {22'h0, v[9:0]});
    chk({22'h0, push}, {22'h0, pc});
  endtask : wait_take
  task t_reset;
    rd(`TSIU_ADDR_CTRL, 8'h00);
    rd(`TSIU_ADDR_MISC, 8'h00);
    rd(8'h0c, 8'h00);
    rd(`TSIU_ADDR_STAT, 8'h00);
  endtask : t_reset
  task t_edges;
    for (int s = 0; s < 4; s++)
    begin
      wr(`TSIU_ADDR_MISC, {s[1:0], 6'h0});
      wr(`TSIU_ADDR_CTRL, 8'h00);
      pin <= 1'b1;
      repeat (8) @(posedge sys_clk);
      rd(`TSIU_ADDR_CTRL, {3'h0, s[0], 4'h0});
      wr(`TSIU_ADDR_CTRL, 8'h00);
      pin <= 1'b0;
      repeat (8) @(posedge sys_clk);
      rd(`TSIU_ADDR_CTRL, {3'h0, s[1], 4'h0});
    end
  endtask : t_edges
  task t_mask;
    int n;
    wr(`TSIU_ADDR_CTRL, 8'h04);
    pls(3'h1);
    quiet();
    rd(`TSIU_ADDR_CTRL, 8'h24);
    wr(`TSIU_ADDR_CTRL, 8'h25);
    wait_take(`TSIU_VEC_TMR, n);
    rd(`TSIU_ADDR_STAT, 8'h04);
    rd(`TSIU_ADDR_CTRL, 8'h04);
    pls(3'h4);
    rd(`TSIU_ADDR_CTRL, 8'h04);
    pls(3'h2);
    rd(`TSIU_ADDR_CTRL, 8'h05);
  endtask : t_mask
  task t_stack;
    int n;
    sfull <= 1'b1;
    pls(3'h1);
    quiet();
    sfull <= 1'b0;
    wait_take(`TSIU_VEC_TMR, n);
    chk({31'h0, n < 12}, 32'h1);
  endtask : t_stack
  task t_prio;
    int n;
    wr(`TSIU_ADDR_MISC, 8'h40);
    wr(`TSIU_ADDR_CTRL, 8'h06);
    pin <= 1'b1;
    pls(3'h1);
    repeat (8) @(posedge sys_clk);
    wr(`TSIU_ADDR_CTRL, 8'h37);
    wait_take(`TSIU_VEC_PIN, n);
    rd(`TSIU_ADDR_CTRL, 8'h26);
    wr(`TSIU_ADDR_CTRL, 8'h27);
    wait_take(`TSIU_VEC_TMR, n);
  endtask : t_prio
  task t_wake;
    int w;
    int n;
    slp <= 1'b1;
    wr(`TSIU_ADDR_CTRL, 8'h00);
    w = wake_cnt;
    pls(3'h1);
    repeat (6) @(posedge sys_clk);
    chk(wake_cnt, w + 1);
    wr(`TSIU_ADDR_CTRL, 8'h20);
    pls(3'h1);
    repeat (6) @(posedge sys_clk);
    chk(wake_cnt, w + 1);
    wr(`TSIU_ADDR_CTRL, 8'h05);
    repeat (20) @(posedge sys_clk);
    pls(3'h1);
    wait_take(`TSIU_VEC_TMR, n);
    chk({31'h0, n >= 8 && n <= 16}, 32'h1);
    slp <= 1'b0;
  endtask : t_wake
  initial
  begin
    sys_clk = 1'b0;
    rst = 1'b1;
    {hsel, hwrite, pin, tmr, sfull, ret, return_from_irq_instr, slp} = 8'h00;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = `TSIU_HSIZE_WORD;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    t_reset();
    t_edges();
    t_mask();
    t_stack();
    t_prio();
    t_wake();
    test_done();
  end
endmodule : two_source_interrupt_unit_bench
`default_nettype wire
